//--- rtl/prio_ctrl_regs.sv
/*
  Priority control registers 8..14: seven 16-bit registers of 3-bit
  source priority fields, written and read over a plain register port,
  with every field presented continuously to the arbitration logic.
  Assumes synchronous single-cycle strobes, never both at once.
*/
//
// Behaviour
// - Field code 111 means priority level 7, highest for user sources.
// - Codes 1 to 7 select that level directly; 001 is lowest level 1.
// - Code 000 disables the source so it never wins arbitration.
// - Unimplemented bits read zero; writes to them have no effect.
// - Register 8: CAN1 event, CAN1 rx ready, SPI2 event, SPI2 error fields.
// - Register 9: capture 5, 4, 3 and DMA channel 3 done fields.
// - Register 10: compare 7, 6, 5 and capture 6 fields.
// - Register 11: timer 6, DMA 4 done, compare 8; bits 7-3 unimplemented.
// - Register 13: CAN2 rx ready, ext irq 4, ext irq 3, timer 9 fields.
// - Register 14: codec error at 14-12, CAN2 event at 2-0; 11-3 unused.
// - Reset sets every implemented field to level 4 (100).
`timescale 1ns/1ps
module prio_ctrl_regs
  import prio_regs_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire prio_regs_pkg::reg_req_t           regReq,
  output logic [prio_regs_pkg::DATA_W-1:0]       rdData,
  output prio_regs_pkg::src_prio_t               srcPrio,
  output prio_regs_pkg::src_enable_t             srcEnable
);
  import prio_regs_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] bank [NUM_REGS];
  logic [DATA_W-1:0] next_rdData;
  wire               addrHit = (regReq.addr < ADDR_W'(NUM_REGS));

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      wire writeThis = regReq.wrStrobe && (regReq.addr == ADDR_W'(gi));
      // implemented bits
      // A constant mask, so the reset branch loads constants only
      localparam logic [DATA_W-1:0] IMPL_BITS = (gi == int'(PRIO_CTRL_11_IDX)) ? MASK_REG11
                                              : (gi == int'(PRIO_CTRL_14_IDX)) ? MASK_REG14 : MASK_FULL;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bank[gi] <= RESET_FULL & IMPL_BITS;
        end else if (writeThis) begin
          bank[gi] <= regReq.wrData & IMPL_BITS;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped indices read zero; reads have no side effect
  assign next_rdData = (regReq.rdStrobe && addrHit) ? bank[regReq.addr] : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------------------------------
  // Field map to arbitration
  // ----------------------------------------------------------------
  // continuous outputs straight from the flops
  assign srcPrio.can1_event_prio     = bank[PRIO_CTRL_8_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.can1_rx_ready_prio  = bank[PRIO_CTRL_8_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.spi2_event_prio     = bank[PRIO_CTRL_8_IDX][FIELD_ML_POS +: PRIO_W];
  assign srcPrio.spi2_error_prio     = bank[PRIO_CTRL_8_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.capture5_prio       = bank[PRIO_CTRL_9_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.capture4_prio       = bank[PRIO_CTRL_9_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.capture3_prio       = bank[PRIO_CTRL_9_IDX][FIELD_ML_POS +: PRIO_W];
  assign srcPrio.dma_ch3_done_prio   = bank[PRIO_CTRL_9_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.compare7_prio       = bank[PRIO_CTRL_10_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.compare6_prio       = bank[PRIO_CTRL_10_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.compare5_prio       = bank[PRIO_CTRL_10_IDX][FIELD_ML_POS +: PRIO_W];
  assign srcPrio.capture6_prio       = bank[PRIO_CTRL_10_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.timer6_prio         = bank[PRIO_CTRL_11_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.dma_ch4_done_prio   = bank[PRIO_CTRL_11_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.compare8_prio       = bank[PRIO_CTRL_11_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.timer8_prio         = bank[PRIO_CTRL_12_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.i2c2_master_prio    = bank[PRIO_CTRL_12_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.i2c2_slave_prio     = bank[PRIO_CTRL_12_IDX][FIELD_ML_POS +: PRIO_W];
  assign srcPrio.timer7_prio         = bank[PRIO_CTRL_12_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.can2_rx_ready_prio  = bank[PRIO_CTRL_13_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.ext_irq4_prio       = bank[PRIO_CTRL_13_IDX][FIELD_MH_POS +: PRIO_W];
  assign srcPrio.ext_irq3_prio       = bank[PRIO_CTRL_13_IDX][FIELD_ML_POS +: PRIO_W];
  assign srcPrio.timer9_prio         = bank[PRIO_CTRL_13_IDX][FIELD_LO_POS +: PRIO_W];
  assign srcPrio.codec_if_error_prio = bank[PRIO_CTRL_14_IDX][FIELD_HI_POS +: PRIO_W];
  assign srcPrio.can2_event_prio     = bank[PRIO_CTRL_14_IDX][FIELD_LO_POS +: PRIO_W];

  // ----------------------------------------------------------------
  // Enables for arbitration
  // ----------------------------------------------------------------
  // zero code disables; levels pass through unchanged
  localparam int unsigned NUM_SRC = $bits(src_prio_t) / PRIO_W;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_en
      assign srcEnable[gi] = (srcPrio[gi*PRIO_W +: PRIO_W] != PRIO_DISABLED);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // write lands next cycle
  chk_write_updates:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_9_IDX
    |=> bank[PRIO_CTRL_9_IDX] == ($past(regReq.wrData) & MASK_FULL))
  else $error("register 9 did not take written value");

  chk_unimpl_zero:
  assert property (@(posedge clk) disable iff (rst)
    (bank[PRIO_CTRL_11_IDX] & ~MASK_REG11) == 16'h0000 && (bank[PRIO_CTRL_14_IDX] & ~MASK_REG14) == 16'h0000)
  else $error("unimplemented bits hold a one");

  chk_read_data:
  assert property (@(posedge clk) disable iff (rst)
    regReq.rdStrobe && regReq.addr == PRIO_CTRL_14_IDX && !regReq.wrStrobe
    |=> rdData == ($past(bank[PRIO_CTRL_14_IDX]) & MASK_REG14))
  else $error("read data wrong for register 14");

  chk_reset_level:
  assert property (@(posedge clk) $fell(rst) |-> srcPrio.timer6_prio == PRIO_RESET && srcPrio.can2_event_prio == PRIO_RESET)
  else $error("fields not at level 4 after reset");

  chk_zero_disables:
  assert property (@(posedge clk) disable iff (rst)
    srcEnable.codec_if_error == (srcPrio.codec_if_error_prio != PRIO_DISABLED))
  else $error("disable code mismatch");

  chk_top_level:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_8_IDX && regReq.wrData[14:12] == 3'h7
    |=> srcPrio.can1_event_prio == PRIO_HIGHEST && srcEnable.can1_event)
  else $error("code 111 not level 7");

  chk_low_level:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_12_IDX && regReq.wrData[2:0] == 3'h1
    |=> srcPrio.timer7_prio == PRIO_LOWEST ##1 srcPrio.timer7_prio == PRIO_LOWEST || $past(regReq.wrStrobe))
  else $error("code 001 not level 1");

  chk_field_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_13_IDX
    |=> srcPrio.ext_irq3_prio == $past(regReq.wrData[6:4]) && srcPrio.timer9_prio == $past(regReq.wrData[2:0]))
  else $error("register 13 field map wrong");

  // ----------------------------------------------------------------
  // Checks: field maps and codes
  // ----------------------------------------------------------------
  // register 8 map
  chk_reg8_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_8_IDX
    |=> srcPrio.can1_event_prio == $past(regReq.wrData[14:12])
        && srcPrio.can1_rx_ready_prio == $past(regReq.wrData[10:8])
        && srcPrio.spi2_event_prio == $past(regReq.wrData[6:4])
        && srcPrio.spi2_error_prio == $past(regReq.wrData[2:0]))
  else $error("register 8 field map wrong");

  chk_reg9_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_9_IDX
    |=> srcPrio.capture5_prio == $past(regReq.wrData[14:12])
        && srcPrio.capture4_prio == $past(regReq.wrData[10:8])
        && srcPrio.capture3_prio == $past(regReq.wrData[6:4])
        && srcPrio.dma_ch3_done_prio == $past(regReq.wrData[2:0]))
  else $error("register 9 field map wrong");

  chk_reg10_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_10_IDX
    |=> srcPrio.compare7_prio == $past(regReq.wrData[14:12])
        && srcPrio.compare6_prio == $past(regReq.wrData[10:8])
        && srcPrio.compare5_prio == $past(regReq.wrData[6:4])
        && srcPrio.capture6_prio == $past(regReq.wrData[2:0]))
  else $error("register 10 field map wrong");

  chk_reg11_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_11_IDX
    |=> srcPrio.timer6_prio == $past(regReq.wrData[14:12])
        && srcPrio.dma_ch4_done_prio == $past(regReq.wrData[10:8])
        && srcPrio.compare8_prio == $past(regReq.wrData[2:0]))
  else $error("register 11 field map wrong");

  chk_reg12_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_12_IDX
    |=> srcPrio.timer8_prio == $past(regReq.wrData[14:12])
        && srcPrio.i2c2_master_prio == $past(regReq.wrData[10:8])
        && srcPrio.i2c2_slave_prio == $past(regReq.wrData[6:4])
        && srcPrio.timer7_prio == $past(regReq.wrData[2:0]))
  else $error("register 12 field map wrong");

  chk_reg13_high:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_13_IDX
    |=> srcPrio.can2_rx_ready_prio == $past(regReq.wrData[14:12])
        && srcPrio.ext_irq4_prio == $past(regReq.wrData[10:8]))
  else $error("register 13 high field map wrong");

  chk_reg14_map:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_14_IDX
    |=> srcPrio.codec_if_error_prio == $past(regReq.wrData[14:12])
        && srcPrio.can2_event_prio == $past(regReq.wrData[2:0]))
  else $error("register 14 field map wrong");

  chk_level_direct:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_9_IDX && regReq.wrData[2:0] != PRIO_DISABLED
    |=> srcEnable.dma_ch3_done && srcPrio.dma_ch3_done_prio == $past(regReq.wrData[2:0]))
  else $error("nonzero code not taken as its level");

  chk_disabled_write:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && regReq.addr == PRIO_CTRL_10_IDX && regReq.wrData[2:0] == PRIO_DISABLED
    |=> !srcEnable.capture6)
  else $error("zero code left the source enabled");

  // ----------------------------------------------------------------
  // Checks: reset and hold
  // ----------------------------------------------------------------
  // Set at once when reset rises, so it is high at every edge that samples reset high
  logic rstHeld;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstHeld <= 1'b1;
    end else begin
      rstHeld <= 1'b0;
    end
  end

  chk_reset_fields:
  assert property (@(posedge clk)
    rst && rstHeld |-> srcPrio == {NUM_SRC{PRIO_RESET}} && rdData == 16'h0000)
  else $error("fields not at level 4 during reset");

  chk_reset_enables:
  assert property (@(posedge clk)
    rst && rstHeld |-> srcEnable == '1)
  else $error("source disabled during reset");

  chk_hold_value:
  assert property (@(posedge clk) disable iff (rst)
    !regReq.wrStrobe |=> $stable(srcPrio))
  else $error("priority changed without a write");

  chk_unmapped_write:
  assert property (@(posedge clk) disable iff (rst)
    regReq.wrStrobe && !addrHit |=> $stable(srcPrio))
  else $error("unmapped write changed a priority");

  // ----------------------------------------------------------------
  // Checks: read port
  // ----------------------------------------------------------------
  // idle port reads zero
  chk_read_idle:
  assert property (@(posedge clk) disable iff (rst)
    !regReq.rdStrobe |=> rdData == 16'h0000)
  else $error("read data not zero outside a read");

  chk_unmapped_read:
  assert property (@(posedge clk) disable iff (rst)
    regReq.rdStrobe && !addrHit |=> rdData == 16'h0000)
  else $error("unmapped index did not read zero");

  chk_reg11_read:
  assert property (@(posedge clk) disable iff (rst)
    regReq.rdStrobe && regReq.addr == PRIO_CTRL_11_IDX
    |=> rdData[15] == 1'b0 && rdData[11] == 1'b0 && rdData[7:3] == 5'h00)
  else $error("register 11 unused bits read nonzero");

  chk_reg9_read:
  assert property (@(posedge clk) disable iff (rst)
    regReq.rdStrobe && regReq.addr == PRIO_CTRL_9_IDX
    |=> rdData[14:12] == $past(srcPrio.capture5_prio) && rdData[10:8] == $past(srcPrio.capture4_prio)
        && rdData[6:4] == $past(srcPrio.capture3_prio) && rdData[2:0] == $past(srcPrio.dma_ch3_done_prio))
  else $error("register 9 read fields wrong");

  chk_reg13_read:
  assert property (@(posedge clk) disable iff (rst)
    regReq.rdStrobe && regReq.addr == PRIO_CTRL_13_IDX
    |=> rdData[14:12] == $past(srcPrio.can2_rx_ready_prio) && rdData[10:8] == $past(srcPrio.ext_irq4_prio)
        && rdData[6:4] == $past(srcPrio.ext_irq3_prio) && rdData[2:0] == $past(srcPrio.timer9_prio))
  else $error("register 13 read fields wrong");

  chk_read_after_write:
  assert property (@(posedge clk) disable iff (rst)
    (regReq.wrStrobe && regReq.addr == PRIO_CTRL_12_IDX)
    ##1 (regReq.rdStrobe && regReq.addr == PRIO_CTRL_12_IDX)
    |=> rdData == ($past(regReq.wrData, 2) & MASK_FULL))
  else $error("read after write missed the new value");

endmodule : prio_ctrl_regs

//--- rtl/prio_regs_pkg.sv
/*
  Package for the priority control register bank 8..14: register indices,
  field positions, reset values, implemented-bit masks and carrier types.
  Assumes a 16-bit plain register port and one 100 MHz clock.
*/
package prio_regs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned NUM_REGS = 7;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PRIO_CTRL_8_IDX  = 3'h0;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_9_IDX  = 3'h1;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_10_IDX = 3'h2;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_11_IDX = 3'h3;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_12_IDX = 3'h4;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_13_IDX = 3'h5;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_14_IDX = 3'h6;

  // ----------------------------------------------------------------
  // Field positions (low bit of each 3-bit field)
  // ----------------------------------------------------------------
  localparam int unsigned FIELD_HI_POS  = 12;
  localparam int unsigned FIELD_MH_POS  = 8;
  localparam int unsigned FIELD_ML_POS  = 4;
  localparam int unsigned FIELD_LO_POS  = 0;

  // ----------------------------------------------------------------
  // Priority codes and reset values
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_LOWEST   = 3'h1;
  localparam logic [PRIO_W-1:0] PRIO_HIGHEST  = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h4;

  localparam logic [DATA_W-1:0] MASK_FULL  = 16'h7777;
  localparam logic [DATA_W-1:0] MASK_REG11 = 16'h7707;
  localparam logic [DATA_W-1:0] MASK_REG14 = 16'h7007;
  localparam logic [DATA_W-1:0] RESET_FULL = 16'h4444;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wrStrobe;
    logic              rdStrobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } reg_req_t;

  typedef struct packed {
    logic [PRIO_W-1:0] can1_event_prio;
    logic [PRIO_W-1:0] can1_rx_ready_prio;
    logic [PRIO_W-1:0] spi2_event_prio;
    logic [PRIO_W-1:0] spi2_error_prio;
    logic [PRIO_W-1:0] capture5_prio;
    logic [PRIO_W-1:0] capture4_prio;
    logic [PRIO_W-1:0] capture3_prio;
    logic [PRIO_W-1:0] dma_ch3_done_prio;
    logic [PRIO_W-1:0] compare7_prio;
    logic [PRIO_W-1:0] compare6_prio;
    logic [PRIO_W-1:0] compare5_prio;
    logic [PRIO_W-1:0] capture6_prio;
    logic [PRIO_W-1:0] timer6_prio;
    logic [PRIO_W-1:0] dma_ch4_done_prio;
    logic [PRIO_W-1:0] compare8_prio;
    logic [PRIO_W-1:0] timer8_prio;
    logic [PRIO_W-1:0] i2c2_master_prio;
    logic [PRIO_W-1:0] i2c2_slave_prio;
    logic [PRIO_W-1:0] timer7_prio;
    logic [PRIO_W-1:0] can2_rx_ready_prio;
    logic [PRIO_W-1:0] ext_irq4_prio;
    logic [PRIO_W-1:0] ext_irq3_prio;
    logic [PRIO_W-1:0] timer9_prio;
    logic [PRIO_W-1:0] codec_if_error_prio;
    logic [PRIO_W-1:0] can2_event_prio;
  } src_prio_t;

  typedef struct packed {
    logic can1_event;
    logic can1_rx_ready;
    logic spi2_event;
    logic spi2_error;
    logic capture5;
    logic capture4;
    logic capture3;
    logic dma_ch3_done;
    logic compare7;
    logic compare6;
    logic compare5;
    logic capture6;
    logic timer6;
    logic dma_ch4_done;
    logic compare8;
    logic timer8;
    logic i2c2_master;
    logic i2c2_slave;
    logic timer7;
    logic can2_rx_ready;
    logic ext_irq4;
    logic ext_irq3;
    logic timer9;
    logic codec_if_error;
    logic can2_event;
  } src_enable_t;

endpackage : prio_regs_pkg

//--- testbench/prio_arbiter_model.sv
/*
  Stand-in for the arbitration logic fed by the priority outputs. It
  reports the highest level among enabled sources.
  Assumes every source is pending at all times.
*/
`timescale 1ns/1ps
module prio_arbiter_model
  import prio_regs_pkg::*;
(
  input  wire prio_regs_pkg::src_prio_t    srcPrio,
  input  wire prio_regs_pkg::src_enable_t  srcEnable,
  output logic [prio_regs_pkg::PRIO_W-1:0] winLevel
);
  import prio_regs_pkg::*;
  // ----------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------
  // code is level, 000 never wins
  always_comb begin
    winLevel = PRIO_DISABLED;
    for (int i = 0; i < $bits(src_enable_t); i++) begin
      if (srcEnable[i] && srcPrio[3*i +: 3] > winLevel) begin
        winLevel = srcPrio[3*i +: 3];
      end
    end
  end
endmodule : prio_arbiter_model

//--- testbench/tb_prio_ctrl_regs.sv
/*
  Bench for the priority register bank: a table of writes with read-back,
  then reset cases.
  Assumes the package and the arbiter model beside the design.
*/
`timescale 1ns/1ps
module tb_prio_ctrl_regs;
  import prio_regs_pkg::*;
  typedef struct { logic [2:0] a; logic [15:0] d; logic [15:0] e; } row_t;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  reg_req_t          regReq = '0;
  logic [DATA_W-1:0] rdData;
  src_prio_t         srcPrio;
  src_enable_t       srcEnable;
  logic [PRIO_W-1:0] winLevel;
  logic [DATA_W-1:0] img [NUM_REGS];
  int                num_errors = 0;
  int                n_checks = 0;
  row_t              rows [12] = '{
    '{3'h0, 16'hFFFF, 16'h7777}, '{3'h1, 16'h1234, 16'h1234}, '{3'h2, 16'h0000, 16'h0000},
    '{3'h3, 16'hFFFF, 16'h7707}, '{3'h4, 16'h7531, 16'h7531}, '{3'h5, 16'h1111, 16'h1111},
    '{3'h6, 16'hFFFF, 16'h7007}, '{3'h7, 16'hFFFF, 16'h0000}, '{3'h0, 16'h8888, 16'h0000},
    '{3'h3, 16'h00F8, 16'h0000}, '{3'h6, 16'h0FF8, 16'h0000}, '{3'h1, 16'h7654, 16'h7654}};

  prio_ctrl_regs dut (.clk(clk), .rst(rst), .regReq(regReq), .rdData(rdData), .srcPrio(srcPrio),
                      .srcEnable(srcEnable));
  prio_arbiter_model partner (.srcPrio(srcPrio), .srcEnable(srcEnable), .winLevel(winLevel));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [74:0] seen, input logic [74:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reset_img();
    for (int i = 0; i < NUM_REGS; i++) begin
      img[i] = RESET_FULL & ((i == 3) ? MASK_REG11 : (i == 6) ? MASK_REG14 : MASK_FULL);
    end
  endtask : reset_img

  // Unimplemented fields are skipped, so the order matches the carrier
  task automatic check_outs();
    logic [74:0] v;
    logic [24:0] en;
    logic [2:0]  top;
    v = '0;
    top = '0;
    for (int r = 0; r < NUM_REGS; r++) begin
      for (int p = 12; p >= 0; p -= 4) begin
        if (!((r == 3 && p == 4) || (r == 6 && p != 12 && p != 0))) begin
          v = {v[71:0], img[r][p +: 3]};
        end
      end
    end
    for (int i = 0; i < 25; i++) begin
      en[i] = |v[3*i +: 3];
      top = (v[3*i +: 3] > top) ? v[3*i +: 3] : top;
    end
    check("srcPrio", srcPrio, v);
    check("srcEnable", srcEnable, en);
    check("winLevel", winLevel, top);
  endtask : check_outs

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk) regReq <= '{1'b0, 1'b1, a, 16'h0000};
    #1 check_outs();
    @(posedge clk) regReq <= '0;
    #1 check("rdData", rdData, e);
    @(posedge clk) #1 check("rdIdle", rdData, 0);
  endtask : rd

  task automatic print_verdict();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reset_img();
    #1 check_outs();
    // Write then read with no gap; unmapped index leaves the bank alone
    foreach (rows[i]) begin
      if (rows[i].a != 3'h7) img[rows[i].a] = rows[i].e;
      @(posedge clk) regReq <= '{1'b1, 1'b0, rows[i].a, rows[i].d};
      rd(rows[i].a, rows[i].e);
    end
    // Reset in mid-run while a read is attempted
    @(posedge clk) rst <= 1'b1;
    reset_img();
    @(posedge clk) regReq <= '{1'b0, 1'b1, 3'h1, 16'h0000};
    @(posedge clk) regReq <= '0;
    #1 check("rdReset", rdData, 0);
    check_outs();
    @(posedge clk) rst <= 1'b0;
    rd(3'h3, 16'h4404);
    rd(3'h6, 16'h4004);
    rd(3'h0, 16'h4444);
    print_verdict();
  end

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_prio_ctrl_regs
